// file: common/ebk_cfg.svh
`ifndef EBK_CFG_SVH
`define EBK_CFG_SVH

// register byte offsets inside the on-chip window
`define EBK_OFS_BIC 12'h000
`define EBK_OFS_RSVD 12'h004
`define EBK_OFS_IRQ 12'h008
`define EBK_OFS_PKD 12'h00C
`define EBK_OFS_DIR 12'h010
`define EBK_OFS_PULL 12'h014
`define EBK_OFS_MCTL 12'h018

// field positions
`define EBK_BIT_E_CLOCK_STRETCH_ENABLE 0
`define EBK_BIT_IRQ_EDGE_SELECT 7
`define EBK_BIT_IRQ_PIN_ENABLE 6
`define EBK_BIT_EMK 1
`define EBK_BIT_PORT_K_PULL_ENABLE 7

// reset values
`define EBK_RST_BIC 8'h01
`define EBK_RST_IRQ 8'h40
`define EBK_RST_PKD 8'h00
`define EBK_RST_DIR 8'h00
`define EBK_RST_PULL 8'h00
`define EBK_RST_MCTL 8'h00

// timing: clock period, e clock half period, chip select gap
`define EBK_CLK_NS 5
`define EBK_E_HALF_NS 10
`define EBK_E_HALF_CYC ((`EBK_E_HALF_NS) / (`EBK_CLK_NS))
`define EBK_CS_GAP_NS 5
`define EBK_CS_GAP_CYC ((`EBK_CS_GAP_NS) / (`EBK_CLK_NS))

`endif

// file: common/ebk_pkg.sv
package ebk_pkg;

    // operating mode, as strapped on the mode pins
    typedef enum logic [2:0] {
        ebk_md_spec_single = 3'b000,
        ebk_md_emul_narrow = 3'b001,
        ebk_md_spec_test = 3'b010,
        ebk_md_emul_wide = 3'b011,
        ebk_md_norm_single = 3'b100,
        ebk_md_norm_narrow = 3'b101,
        ebk_md_periph = 3'b110,
        ebk_md_norm_wide = 3'b111
    } ebk_mode_t;

    // register bus slave states
    typedef enum logic [1:0] {
        ebk_st_idle = 2'b00,
        ebk_st_ext = 2'b01,
        ebk_st_done = 2'b10
    } ebk_bus_st_t;

endpackage

// file: src/ebk_bus_e_clock_gen.sv
`include "ebk_cfg.svh"

module ebk_bus_e_clock_gen (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic stretch_en, // effective stretch enable
    input wire logic ext_busy, // external cycle in progress
    output logic bus_e_clock, // e clock pin
    output logic cs_gap // force chip selects inactive
);
    localparam logic [3:0] DIV_LAST = 4'(`EBK_E_HALF_CYC - 1);
    localparam logic [3:0] GAP_CYC = 4'(`EBK_CS_GAP_CYC);

    logic [3:0] div_q;
    logic [3:0] gap_q;
    logic e_q;
    logic e_d;
    wire free_tick = (div_q == DIV_LAST);
    wire e_fall = e_q & ~e_d;
    wire gap_skip = ext_busy & ~stretch_en;

    // e follows the external cycle when stretching, else toggles freely
    assign e_d = stretch_en ? ext_busy : (free_tick ? ~e_q : e_q);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 4'h0;
            e_q <= 1'b0;
        end else begin
            div_q <= (stretch_en | free_tick) ? 4'h0 : div_q + 4'h1;
            e_q <= e_d;
        end
    end

    // quarter-cycle chip select release after each falling e edge, except free-running edges during an external cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 4'h0;
        end else if (e_fall && !gap_skip) begin
            gap_q <= GAP_CYC;
        end else if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
        end
    end

    assign bus_e_clock = e_q;
    assign cs_gap = (gap_q != 4'h0);

    a_e_free_run: assert property (@(posedge clk) disable iff (!reset_n)
        (!stretch_en && free_tick) |=> (e_q != $past(e_q)))
        else $error("e clock failed to toggle while free running");
    a_e_stretch_high: assert property (@(posedge clk) disable iff (!reset_n)
        (stretch_en && ext_busy) |=> e_q || !$past(stretch_en))
        else $error("e clock not high through stretched access");
endmodule

// file: src/ebk_irq_sense.sv
module ebk_irq_sense (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic irq_pin_n, // raw interrupt pin, low active
    input wire logic edge_sel, // irq_edge_select
    input wire logic pin_enable, // irq_pin_enable
    input wire logic irq_serviced, // interrupt being serviced
    output logic irq_request, // request to interrupt logic
    output logic edge_latch // falling edge latch state
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic latch_q;
    logic req_q;
    wire pin_fall = s3_q & ~s2_q;

    // two-stage synchroniser plus history for edge detect
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= irq_pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // edge latch: disabled with the pin, new edge beats service clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_q <= 1'b0;
        end else if (!pin_enable) begin
            latch_q <= 1'b0;
        end else if (edge_sel && pin_fall) begin
            latch_q <= 1'b1;
        end else if (irq_serviced) begin
            latch_q <= 1'b0;
        end
    end

    // level or edge request, gated by the pin enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= pin_enable & (edge_sel ? latch_q : ~s2_q);
        end
    end

    assign irq_request = req_q;
    assign edge_latch = latch_q;

    a_edge_latch_set: assert property (@(posedge clk) disable iff (!reset_n)
        (pin_enable && edge_sel && pin_fall) |=> latch_q ##1 req_q || !pin_enable)
        else $error("falling edge not latched into a request");
    a_level_request: assert property (@(posedge clk) disable iff (!reset_n)
        (pin_enable && !edge_sel && !s2_q) |=> req_q)
        else $error("low level not requested");
    a_pin_disabled: assert property (@(posedge clk) disable iff (!reset_n)
        (!pin_enable) |=> !latch_q && !req_q)
        else $error("disabled pin still reaches interrupt logic");
    c_edge_request: cover property (@(posedge clk) disable iff (!reset_n)
        edge_sel && pin_fall ##1 latch_q ##1 req_q);
endmodule

// file: src/ebk_top.sv
`include "ebk_cfg.svh"

// Functional notes
// - stretch enable 0: e clock runs freely, never stretched
// - stretch enable 1: e high through external accesses, low otherwise
// - stretch enable has no effect in single-chip modes
// - stretch enable: write once in normal and emulation, anytime in special
// - expanded and peripheral: control and reserved location go off chip
// - reserved location reads zero, writes discarded
// - edge select 0: low level interrupt; 1: falling edges only
// - edge select readable anytime; write once normal/emulation, anytime special
// - edge mode latches falling edges; cleared by reset, servicing or pin enable 0
// - pin enable connects the interrupt pin; read and write anytime
// - pin enable 0 disables the edge latch
// - gpio: direction 1 drives the pin, 0 leaves it an input
// - data read returns pin for inputs, output register for outputs
// - port data goes off chip in expanded with emulate set, and always in peripheral
// - input pins pulled up when pull enable set, else floating
// - bit 7 is the emulation chip select or gpio per emulate
// - chip selects release for a quarter cycle after e falls, unless free running during an external cycle
// - bit 6 is the external chip select or gpio per emulate
// - bits 5 to 0 carry page address bits 19 to 14 in emulation
// - expanded with emulate removes port regs; always mapped single chip
// - pull enable is bit 7 of the pull register
module ebk_top
(
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [20:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [2:0] mode_pins, // mode straps
    input wire logic irq_pin_n, // external interrupt pin
    input wire logic irq_serviced, // interrupt service strobe
    output logic irq_request, // request to interrupt logic
    output logic ext_req, // external cycle request
    output logic ext_write, // external cycle direction
    output logic [20:0] ext_addr, // external cycle address
    output logic [7:0] ext_wdata, // external write data
    input wire logic [7:0] ext_rdata, // external read data
    input wire logic ext_ack, // external cycle acknowledge
    output logic bus_e_clock, // e clock pin
    input wire logic [7:0] pk_in, // port k pin levels
    output logic [7:0] pk_out, // port k pin drive values
    output logic [7:0] pk_oe, // port k output enables
    output logic [7:0] pk_pull // port k pull-up enables
);
    import ebk_pkg::*;

    ebk_bus_st_t st_q;
    ebk_mode_t mode_q;
    logic [2:0] msync1_q;
    logic [2:0] msync2_q;
    logic [2:0] mode_cap_q;
    logic [7:0] pks1_q;
    logic [7:0] pks2_q;
    logic ack1_q;
    logic ack2_q;
    logic ack3_q;
    logic e_clock_stretch_enable_q;
    logic bic_once_q;
    logic irq_edge_select_q;
    logic irq_pin_enable_q;
    logic irq_edge_select_once_q;
    logic [7:0] pkd_q;
    logic [7:0] dir_q;
    logic port_k_pull_enable_q;
    logic emk_q;
    logic emk_once_q;
    logic [7:0] rdata_q;
    logic err_q;
    logic loc_q;
    logic ext_mem_q;
    logic [5:0] page_q;
    logic [20:0] ext_addr_q;
    logic [7:0] ext_wdata_q;
    logic ext_write_q;
    logic cs_gap;
    logic edge_latch;

    // mode class decode
    wire single = (mode_q == ebk_md_spec_single) | (mode_q == ebk_md_norm_single);
    wire periph = (mode_q == ebk_md_periph);
    wire special = (mode_q == ebk_md_spec_single) | (mode_q == ebk_md_spec_test) | periph;
    wire emul = (mode_q == ebk_md_emul_narrow) | (mode_q == ebk_md_emul_wide);
    wire normal = ~special & ~emul;
    wire expanded = ~single & ~periph;

    // address decode: upper half is external memory, low page holds registers
    wire [11:0] ofs = paddr[11:0];
    wire reg_page = ~paddr[20] & (paddr[19:12] == 8'h00);
    wire ofs_bic = reg_page & (ofs == `EBK_OFS_BIC);
    wire ofs_rsvd = reg_page & (ofs == `EBK_OFS_RSVD);
    wire ofs_irq = reg_page & (ofs == `EBK_OFS_IRQ);
    wire ofs_pkd = reg_page & (ofs == `EBK_OFS_PKD);
    wire ofs_dir = reg_page & (ofs == `EBK_OFS_DIR);
    wire ofs_pull = reg_page & (ofs == `EBK_OFS_PULL);
    wire ofs_mctl = reg_page & (ofs == `EBK_OFS_MCTL);

    // on-chip map depends on mode and emulate
    wire bic_mapped = single;
    wire pk_mapped = single | (expanded & ~emk_q);
    wire hit_bic = ofs_bic & bic_mapped;
    wire hit_rsvd = ofs_rsvd & bic_mapped;
    wire hit_pkd = ofs_pkd & pk_mapped;
    wire hit_dir = ofs_dir & pk_mapped;
    wire hit_local = hit_bic | hit_rsvd | ofs_irq | hit_pkd | hit_dir | ofs_pull | ofs_mctl;
    wire known_reg = ofs_bic | ofs_rsvd | ofs_pkd | ofs_dir;
    wire hit_echo = paddr[20] | (known_reg & ~hit_local);

    // apb phases
    wire access = psel & penable;
    wire start = access & (st_q == ebk_st_idle);
    wire ack_rise = ack2_q & ~ack3_q;
    wire commit = access & pready & pwrite & loc_q;

    // read value of port k: pin for inputs, register for outputs
    wire [7:0] pkd_rd = (dir_q & pkd_q) | (~dir_q & pks2_q);
    wire [7:0] bic_rd = {7'h00, e_clock_stretch_enable_q} << `EBK_BIT_E_CLOCK_STRETCH_ENABLE;
    wire [7:0] irq_rd = ({7'h00, irq_edge_select_q} << `EBK_BIT_IRQ_EDGE_SELECT) | ({7'h00, irq_pin_enable_q} << `EBK_BIT_IRQ_PIN_ENABLE);
    wire [7:0] pull_rd = {7'h00, port_k_pull_enable_q} << `EBK_BIT_PORT_K_PULL_ENABLE;
    wire [7:0] mctl_rd = {7'h00, emk_q} << `EBK_BIT_EMK;
    wire [7:0] rd_mux = hit_bic ? bic_rd :
                        ofs_irq ? irq_rd :
                        hit_pkd ? pkd_rd :
                        hit_dir ? dir_q :
                        ofs_pull ? pull_rd :
                        ofs_mctl ? mctl_rd : 8'h00;

    // write permissions
    wire bic_ok = special | ~bic_once_q;
    wire irq_edge_select_ok = special | ~irq_edge_select_once_q;
    wire emk_ok = special | (normal & ~emk_once_q);
    wire wr_bic = commit & hit_bic;
    wire wr_irq = commit & ofs_irq;
    wire wr_pkd = commit & hit_pkd;
    wire wr_dir = commit & hit_dir;
    wire wr_pull = commit & ofs_pull;
    wire wr_mctl = commit & ofs_mctl;

    // port k function selection
    wire emul_use = emk_q & expanded;
    wire stretch_eff = e_clock_stretch_enable_q & ~single;
    wire cs_busy = (st_q == ebk_st_ext);
    wire ecs_n = ~(cs_busy & ~ext_mem_q) | cs_gap;
    wire xcs_n = ~(cs_busy & ext_mem_q) | cs_gap;

    // mode straps synchronised, captured once the synchroniser has refilled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msync1_q <= 3'h0;
            msync2_q <= 3'h0;
            mode_cap_q <= 3'h0;
            mode_q <= ebk_md_norm_single;
        end else begin
            msync1_q <= mode_pins;
            msync2_q <= msync1_q;
            mode_cap_q <= {mode_cap_q[1:0], 1'b1};
            if (mode_cap_q == 3'h3) begin
                mode_q <= ebk_mode_t'(msync2_q);
            end
        end
    end

    // pin and acknowledge synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pks1_q <= 8'h00;
            pks2_q <= 8'h00;
            ack1_q <= 1'b0;
            ack2_q <= 1'b0;
            ack3_q <= 1'b0;
        end else begin
            pks1_q <= pk_in;
            pks2_q <= pks1_q;
            ack1_q <= ext_ack;
            ack2_q <= ack1_q;
            ack3_q <= ack2_q;
        end
    end

    // apb slave sequencer: local answer in one cycle, echo waits for ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ebk_st_idle;
            rdata_q <= 8'h00;
            err_q <= 1'b0;
            loc_q <= 1'b0;
        end else begin
            unique case (st_q)
                ebk_st_idle: begin
                    if (start) begin
                        st_q <= hit_echo ? ebk_st_ext : ebk_st_done;
                        rdata_q <= rd_mux;
                        loc_q <= hit_local;
                        err_q <= ~hit_local & ~hit_echo;
                    end
                end
                ebk_st_ext: begin
                    if (ack_rise) begin
                        st_q <= ebk_st_done;
                        rdata_q <= ext_rdata;
                    end
                end
                ebk_st_done: begin
                    st_q <= ebk_st_idle;
                end
                default: begin
                    st_q <= ebk_st_idle;
                end
            endcase
        end
    end

    // external cycle address, data and page capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_addr_q <= 21'h00_0000;
            ext_wdata_q <= 8'h00;
            ext_write_q <= 1'b0;
            ext_mem_q <= 1'b0;
            page_q <= 6'h00;
        end else if (start && hit_echo) begin
            ext_addr_q <= paddr;
            ext_wdata_q <= pwdata[7:0];
            ext_write_q <= pwrite;
            ext_mem_q <= paddr[20];
            if (paddr[20]) begin
                page_q <= paddr[19:14];
            end
        end
    end

    // bus interface control: stretch enable with write-once guard
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            e_clock_stretch_enable_q <= 1'(`EBK_RST_BIC >> `EBK_BIT_E_CLOCK_STRETCH_ENABLE);
            bic_once_q <= 1'b0;
        end else if (wr_bic) begin
            bic_once_q <= 1'b1;
            if (bic_ok) begin
                e_clock_stretch_enable_q <= pwdata[`EBK_BIT_E_CLOCK_STRETCH_ENABLE];
            end
        end
    end

    // interrupt control: edge select once, pin enable anytime
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_edge_select_q <= 1'(`EBK_RST_IRQ >> `EBK_BIT_IRQ_EDGE_SELECT);
            irq_pin_enable_q <= 1'(`EBK_RST_IRQ >> `EBK_BIT_IRQ_PIN_ENABLE);
            irq_edge_select_once_q <= 1'b0;
        end else if (wr_irq) begin
            irq_edge_select_once_q <= 1'b1;
            irq_pin_enable_q <= pwdata[`EBK_BIT_IRQ_PIN_ENABLE];
            if (irq_edge_select_ok) begin
                irq_edge_select_q <= pwdata[`EBK_BIT_IRQ_EDGE_SELECT];
            end
        end
    end

    // port k data, direction and pull enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pkd_q <= `EBK_RST_PKD;
            dir_q <= `EBK_RST_DIR;
            port_k_pull_enable_q <= 1'(`EBK_RST_PULL >> `EBK_BIT_PORT_K_PULL_ENABLE);
        end else begin
            if (wr_pkd) begin
                pkd_q <= pwdata[7:0];
            end
            if (wr_dir) begin
                dir_q <= pwdata[7:0];
            end
            if (wr_pull) begin
                port_k_pull_enable_q <= pwdata[`EBK_BIT_PORT_K_PULL_ENABLE];
            end
        end
    end

    // emulate port k: special anytime, normal once, emulation never
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            emk_q <= 1'(`EBK_RST_MCTL >> `EBK_BIT_EMK);
            emk_once_q <= 1'b0;
        end else if (wr_mctl) begin
            emk_once_q <= 1'b1;
            if (emk_ok) begin
                emk_q <= pwdata[`EBK_BIT_EMK];
            end
        end
    end

    ebk_bus_e_clock_gen u_bus_e_clock (
        .clk(clk),
        .reset_n(reset_n),
        .stretch_en(stretch_eff),
        .ext_busy(cs_busy),
        .bus_e_clock(bus_e_clock),
        .cs_gap(cs_gap)
    );
    ebk_irq_sense u_irq (
        .clk(clk),
        .reset_n(reset_n),
        .irq_pin_n(irq_pin_n),
        .edge_sel(irq_edge_select_q),
        .pin_enable(irq_pin_enable_q),
        .irq_serviced(irq_serviced),
        .irq_request(irq_request),
        .edge_latch(edge_latch)
    );
    // bus answers and external cycle pins
    assign pready = (st_q == ebk_st_done);
    assign pslverr = pready & err_q;
    assign prdata = {24'h00_0000, rdata_q};
    assign ext_req = cs_busy;
    assign ext_addr = ext_addr_q;
    assign ext_wdata = ext_wdata_q;
    assign ext_write = ext_write_q;

    // port k pins: chip selects and page in emulation, else gpio
    assign pk_out = emul_use ? {ecs_n, xcs_n, page_q} : pkd_q;
    assign pk_oe = emul_use ? 8'hFF : dir_q;
    assign pk_pull = (emul_use | ~port_k_pull_enable_q) ? 8'h00 : ~dir_q;
    a_e_clock_stretch_enable_write_once: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_bic && !special && bic_once_q) |=> $stable(e_clock_stretch_enable_q))
        else $error("second stretch write took effect outside special mode");
    a_irq_edge_select_write_once: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_irq && !special && irq_edge_select_once_q) |=> $stable(irq_edge_select_q))
        else $error("second edge select write took effect outside special mode");
    a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (start && hit_rsvd) |=> pready && prdata == 32'h0000_0000)
        else $error("reserved location read nonzero");
    a_pkd_read_mux: assert property (@(posedge clk) disable iff (!reset_n)
        (start && hit_pkd && !pwrite) |=> prdata[7:0] == $past(pkd_rd))
        else $error("port data read mux wrong");
    a_ctrl_echo_off: assert property (@(posedge clk) disable iff (!reset_n)
        (start && ofs_bic && !single) |=> ext_req && !pready)
        else $error("control register not echoed off chip");
    a_pk_echo_off: assert property (@(posedge clk) disable iff (!reset_n)
        (start && ofs_pkd && expanded && emk_q) |=> ext_req)
        else $error("port data not echoed with emulate set");
    a_pk_single_map: assert property (@(posedge clk) disable iff (!reset_n)
        (start && (ofs_pkd || ofs_dir) && single) |=> pready && !ext_req)
        else $error("port registers unmapped in single chip mode");
    a_gpio_dir_drive: assert property (@(posedge clk) disable iff (!reset_n)
        !emul_use |-> pk_oe == dir_q && pk_out == pkd_q)
        else $error("gpio drive does not follow direction");
    a_pull_inputs: assert property (@(posedge clk) disable iff (!reset_n)
        (!emul_use && port_k_pull_enable_q) |-> pk_pull == ~dir_q)
        else $error("input pull-ups not applied");
    a_stretch_single: assert property (@(posedge clk) disable iff (!reset_n)
        single |-> !stretch_eff)
        else $error("stretch active in single chip mode");
    a_cs_gap_high: assert property (@(posedge clk) disable iff (!reset_n)
        (emul_use && cs_gap) |-> pk_out[7:6] == 2'h3)
        else $error("chip select asserted during release gap");
    a_echo_answer: assert property (@(posedge clk) disable iff (!reset_n)
        (cs_busy && ack_rise) |=> pready ##1 !pready)
        else $error("echoed access not answered after ack");
    c_ext_access: cover property (@(posedge clk) disable iff (!reset_n)
        start && hit_echo ##[1:20] pready);
    c_local_write: cover property (@(posedge clk) disable iff (!reset_n)
        wr_pkd ##1 dir_q != 8'h00);
    c_stretch_cycle: cover property (@(posedge clk) disable iff (!reset_n)
        stretch_eff && cs_busy && bus_e_clock);
endmodule

// file: bench/ebk_ext_mem.sv
module ebk_ext_mem (
    input wire logic clk, // system clock
    input wire logic ext_req, // cycle request
    input wire logic ext_write, // cycle direction
    input wire logic [7:0] ext_wdata, // write data
    output logic ext_ack, // acknowledge
    output logic [7:0] ext_rdata // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q;
    int lat;
    // four-phase answer after a varying wait, stale data not held
    initial begin
        ext_ack = 1'b0;
        ext_rdata = 8'h00;
        mem_q = 8'h00;
        lat = 0;
        forever begin
            @(posedge clk);
            if (ext_req === 1'b1 && !ext_ack) begin
                repeat (lat) @(posedge clk);
                lat = (lat + 3) % 7;
                if (ext_write) mem_q = ext_wdata;
                ext_rdata <= mem_q;
                ext_ack <= 1'b1;
            end else if (ext_req === 1'b0 && ext_ack) begin
                ext_ack <= 1'b0;
                ext_rdata <= ~ext_rdata;
            end
        end
    end
endmodule

// file: bench/ebk_top_test.sv
`include "ebk_cfg.svh"
module ebk_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [20:0] paddr = '0, ext_addr;
    logic [31:0] pwdata = '0, prdata;
    logic [2:0] mode_pins = 3'h4;
    logic irq_pin_n = 1, irq_serviced = 0, irq_request, ext_req, ext_write, ext_ack, bus_e_clock;
    logic [7:0] ext_wdata, ext_rdata, pk_in = 8'h00, pk_out, pk_oe, pk_pull, r, d, v;
    int bad_count = 0, compares = 0, cyc = 0;
    ebk_top dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mode_pins, .irq_pin_n, .irq_serviced, .irq_request, .ext_req, .ext_write,
        .ext_addr, .ext_wdata, .ext_rdata, .ext_ack, .bus_e_clock, .pk_in, .pk_out, .pk_oe,
        .pk_pull);
    ebk_ext_mem mem_u (.clk, .ext_req, .ext_write, .ext_wdata, .ext_ack, .ext_rdata);
    // clock and hang ceiling
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {9'h000, a};
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic [2:0] m);
        reset_n <= 1'b0;
        mode_pins <= m;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse_pin();
        irq_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        irq_pin_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [7:0] port_exp(input logic [7:0] dir, input logic [7:0] o,
        input logic [7:0] pin);
        return (dir & o) | (~dir & pin);
    endfunction
    initial begin
        void'($urandom(26511));
        do_reset(3'h4);
        e = bus_e_clock;
        repeat (2) @(posedge clk);
        chk("bus_e_clock_toggle", {7'h00, e ^ bus_e_clock}, 8'h01);
        apb(0, `EBK_OFS_IRQ, 8'h00);
        chk("irq_reset", r, `EBK_RST_IRQ);
        apb(1, `EBK_OFS_BIC, 8'h00);
        apb(1, `EBK_OFS_BIC, 8'h01);
        apb(0, `EBK_OFS_BIC, 8'h00);
        chk("stretch_once", r, 8'h00);
        apb(1, `EBK_OFS_RSVD, 8'hff);
        apb(0, `EBK_OFS_RSVD, 8'h00);
        chk("reserved", r, 8'h00);
        apb(0, 12'h0fc, 8'h00);
        chk("unmapped_err", {7'h00, e}, 8'h01);
        $display("test registers done");
        // random directions, outputs and pin levels with pull-ups on
        apb(1, `EBK_OFS_PULL, 8'h80);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            v = 8'($urandom);
            pk_in <= 8'($urandom);
            apb(1, `EBK_OFS_DIR, d);
            apb(1, `EBK_OFS_PKD, v);
            repeat (3) @(posedge clk);
            apb(0, `EBK_OFS_PKD, 8'h00);
            chk("port_read", r, port_exp(d, v, pk_in));
            chk("port_oe", pk_oe, d);
            chk("port_drive", pk_out & d, v & d);
            chk("port_pull", pk_pull, ~d);
        end
        $display("test port done");
        // level sensing, then edges latched until serviced
        irq_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("irq_level", {7'h00, irq_request}, 8'h01);
        irq_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq_level_off", {7'h00, irq_request}, 8'h00);
        apb(1, `EBK_OFS_IRQ, 8'hc0);
        pulse_pin();
        chk("irq_edge", {7'h00, irq_request}, 8'h01);
        irq_serviced <= 1'b1;
        @(posedge clk);
        irq_serviced <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irq_serviced", {7'h00, irq_request}, 8'h00);
        apb(1, `EBK_OFS_IRQ, 8'h00);
        apb(0, `EBK_OFS_IRQ, 8'h00);
        chk("edge_once", r, 8'h80);
        pulse_pin();
        chk("irq_disabled", {7'h00, irq_request}, 8'h00);
        $display("test irq done");
        // expanded mode: reserved location echoed to the far side
        do_reset(3'h7);
        @(posedge clk);
        e = bus_e_clock;
        repeat (3) @(posedge clk);
        chk("bus_e_clock_idle", {6'h00, e, bus_e_clock}, 8'h00);
        apb(1, `EBK_OFS_RSVD, 8'h3c);
        apb(0, `EBK_OFS_RSVD, 8'h00);
        chk("reserved_echo", r, 8'h3c);
        chk("echo_addr", ext_addr[7:0], 8'(`EBK_OFS_RSVD));
        apb(0, `EBK_OFS_BIC, 8'h00);
        chk("ctrl_echo", r, 8'h3c);
        apb(1, `EBK_OFS_MCTL, 8'h02);
        @(posedge clk);
        chk("emul_pins", pk_out, 8'hc0);
        chk("emul_oe", pk_oe, 8'hff);
        apb(0, `EBK_OFS_PKD, 8'h00);
        chk("port_echo", r, 8'h3c);
        $display("test expanded done");
        stop_test();
    end
endmodule
